// ===== hdl/bpt_pkg.sv
/*
 * shared constants and carrier types of the breakpoint compare and tagging block.
 * assumes a 16-bit cpu bus, a 32-bit ahb-lite register port and one 40 MHz clock.
 */
//
// Contract
// RULE_01: breakpoint 0 in full or dual mode ignores read/write when its enable is 0, else 0 matches writes and 1 reads; code ignores it in swi dual mode.
// RULE_02: breakpoint 1 in dual mode ignores read/write when its enable is 0, else 0 matches writes and 1 reads; code ignores it in interrupt dual mode.
// RULE_03: the high address comparator, reset to zero, is compared with address bits 15 to 8.
// RULE_04: the low address comparator joins the match only when the breakpoint 0 range control is 1.
// RULE_05: the high data comparator matches the high data byte, or the high address byte in dual modes, under mode, enable and mask.
// RULE_06: the low data comparator matches the low data byte, or the low address byte in dual modes, under mode, enable, range and mask.
// RULE_07: tagging starts only on the tagging command, which turns the strobe pin into the low tag and the background pin into the high tag;
// code also starts it on a write of bit 0 set to the tag control register.
// RULE_08: both tag inputs are sampled on each falling edge of the external bus clock.
// RULE_09: each tag input acts on its own byte without regard to the other.
// RULE_10: a low tag level tags its byte; both low tag both bytes, both high tag nothing.
// RULE_11: tagging works in every mode and is turned off as soon as background debug mode becomes active.
// RULE_12: while tagging is active no serial debug command is processed.
// RULE_13: a tag travels with its word through the queue and a tagged head enters background debug mode instead of executing.
// RULE_14: the mode field selects off, interrupt dual address, full breakpoint, or debug dual address.
// RULE_15: with data compare enable 0 the data comparators take part in nothing; with 1 they compare by mode.
// RULE_16: the high mask excludes data bits 15 to 8 and the low mask bits 7 to 0 in full mode.
// RULE_17: a match is declared only when every enabled comparison matches on the same bus cycle.
package bpt_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_CTRL0      = 8'h20;
	localparam logic [7:0] IDX_CTRL1      = 8'h21;
	localparam logic [7:0] IDX_ADDR_HIGH  = 8'h22;
	localparam logic [7:0] IDX_ADDR_LOW   = 8'h23;
	localparam logic [7:0] IDX_DATA_HIGH  = 8'h24;
	localparam logic [7:0] IDX_DATA_LOW   = 8'h25;
	localparam logic [7:0] IDX_TAG_CTRL   = 8'h26;
	localparam logic [7:0] IDX_STATUS     = 8'h27;
	localparam int         ADDR_W         = 10;

	// reset values
	localparam logic [7:0] RST_BYTE       = 8'h00;

	// control 0 field positions
	localparam int         POS_MODE_HI    = 7;
	localparam int         POS_MODE_LO    = 6;
	localparam int         POS_PROG_ONLY  = 5;
	localparam int         POS_BP1_RANGE  = 3;
	localparam int         POS_BP0_RANGE  = 2;
	localparam logic [7:0] CTRL0_MASK     = 8'hec;

	// control 1 field positions
	localparam int         POS_DATA_EN    = 7;
	localparam int         POS_MASK_HIGH  = 6;
	localparam int         POS_MASK_LOW   = 5;
	localparam int         POS_BP1_RWE    = 3;
	localparam int         POS_BP1_RW     = 2;
	localparam int         POS_BP0_RWE    = 1;
	localparam int         POS_BP0_RW     = 0;
	localparam logic [7:0] CTRL1_MASK     = 8'hef;

	// tag control / status field positions
	localparam int         POS_TAG_GO     = 0;
	localparam int         POS_ST_TAGGING = 0;
	localparam int         POS_ST_BDM     = 1;
	localparam int         POS_ST_BP0     = 2;
	localparam int         POS_ST_BP1     = 3;

	// instruction queue depth
	localparam int         QUEUE_DEPTH    = 3;

	// ahb transfer type
	localparam logic [1:0] HTRANS_NONSEQ  = 2'b10;

	// mode field encodings
	typedef enum logic [1:0] {
		MODE_OFF      = 2'b00,
		MODE_SWI_DUAL = 2'b01,
		MODE_FULL     = 2'b10,
		MODE_DBG_DUAL = 2'b11
	} bpt_mode_t;

	// one cpu bus cycle
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [15:0] data;
		logic        rd;   // 1 read, 0 write
	} bpt_bus_t;

	// breakpoint settings
	typedef struct packed {
		logic [7:0]  addr_high;
		logic [7:0]  addr_low;
		logic [7:0]  data_high;
		logic [7:0]  data_low;
		logic [7:0]  ctrl0;
		logic [7:0]  ctrl1;
	} bpt_cfg_t;

	// one queued program word with its tag bits
	typedef struct packed {
		logic [15:0] word;
		logic [1:0]  tag;  // bit 1 high byte, bit 0 low byte
	} bpt_qword_t;

endpackage

// ===== hdl/bpt_cmp.sv
/*
 * one breakpoint comparator: address bytes with optional low byte and r/w qualifier.
 * assumes settings are stable registers on the same clock as the bus sample.
 */
`timescale 1ns/10ps
module bpt_cmp (
	// comparison settings
	input  wire logic        enable,
	input  wire logic [7:0]  ref_high,
	input  wire logic [7:0]  ref_low,
	input  wire logic        use_high,
	input  wire logic        use_low,
	input  wire logic        rw_enable,
	input  wire logic        rw_value,
	// bus cycle
	input  wire logic [7:0]  bus_high,
	input  wire logic [7:0]  bus_low,
	input  wire logic        bus_rd,
	// result
	output logic             hit
);
	logic hi_ok;
	logic lo_ok;
	logic rw_ok;

	// each enabled part must agree in the same cycle
	assign hi_ok = !use_high || (bus_high == ref_high);
	assign lo_ok = !use_low || (bus_low == ref_low);
	assign rw_ok = !rw_enable || (bus_rd == rw_value); // RULE_01 RULE_02
	assign hit   = enable && hi_ok && lo_ok && rw_ok;  // RULE_17
endmodule

// ===== hdl/bpt_queue.sv
/*
 * instruction queue holding program words with their tag bits.
 * assumes the cpu pushes fetched words and pops the head on execution.
 */
`timescale 1ns/10ps
module bpt_queue #(
	parameter int DEPTH = bpt_pkg::QUEUE_DEPTH
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	// fill side
	input  wire logic               push,
	input  wire bpt_pkg::bpt_qword_t in_word,
	// head side
	input  wire logic               pop,
	output bpt_pkg::bpt_qword_t     head_q,
	output logic                    head_valid
);
	bpt_pkg::bpt_qword_t     mem_q [DEPTH];
	logic [$clog2(DEPTH+1)-1:0] cnt_q;
	logic                    do_pop;
	logic                    do_push;

	assign do_pop     = pop && (cnt_q != '0);
	assign do_push    = push && (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0] || do_pop);
	assign head_valid = (cnt_q != '0);
	assign head_q     = mem_q[0];

	// shift register queue, tag stays with its word
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (do_pop) begin
					mem_q[i] <= (i + 1 < DEPTH) ? mem_q[i+1] : '0; // RULE_13
				end
			end
			if (do_push) begin
				mem_q[32'(cnt_q) - (do_pop ? 1 : 0)] <= in_word; // RULE_13
			end
			cnt_q <= cnt_q + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
		end
	end
endmodule

// ===== hdl/bpt_top.sv
/*
 * breakpoint compare registers and instruction tagging with ahb-lite register access.
 * assumes a 16-bit cpu bus sampled on clk, tag pins and external bus clock from pins,
 * and a background debug core that reports active mode and passes serial commands here.
 */
`timescale 1ns/10ps
module bpt_top #(
	parameter int QDEPTH = bpt_pkg::QUEUE_DEPTH
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                resetn,
	// ahb-lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic [31:0]              hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	// cpu bus watch
	input  wire bpt_pkg::bpt_bus_t   cpu_bus,
	// instruction queue
	input  wire logic                fetch_push,
	input  wire logic [15:0]         fetch_word,
	input  wire logic                exec_pop,
	output logic [15:0]              head_word,
	output logic                     head_valid,
	// pins: external bus clock, strobe and background shared with tags
	input  wire logic                external_bus_clock,
	input  wire logic                byte_strobe_pin,
	input  wire logic                background_pin,
	// background debug core
	input  wire logic                tagging_start_command,
	input  wire logic                bdm_active,
	input  wire logic                serial_cmd_valid,
	output logic                     serial_cmd_accept,
	// break outputs
	output logic                     bp0_hit_q,
	output logic                     bp1_hit_q,
	output logic                     swi_request_q,
	output logic                     bdm_request_q,
	output logic                     tag_break_q
);
	bpt_pkg::bpt_cfg_t   cfg_q;
	logic                tagging_q;
	logic                tag_go_q;
	logic [2:0]          external_bus_clock_sync_q;
	logic [1:0]          tlo_sync_q;
	logic [1:0]          thi_sync_q;
	logic [1:0]          tag_latch_q;
	logic                external_bus_clock_fall;
	logic                wr_pend_q;
	logic [7:0]          wr_addr_q;
	logic [7:0]          rd_data;
	logic [7:0]          byte_addr;
	logic                addr_ok;
	bpt_pkg::bpt_mode_t  mode;
	logic                dual;
	logic                data_en;
	logic                bp0_hit;
	logic                bp1_hit;
	logic                full_data_ok;
	bpt_pkg::bpt_qword_t qin;
	bpt_pkg::bpt_qword_t qhead;
	logic                hwdata_unused;

	// ---- register access ----
	assign byte_addr     = haddr[9:2];
	assign addr_ok       = haddr[31:bpt_pkg::ADDR_W] == '0;
	assign hreadyout     = 1'b1;
	assign hresp         = 1'b0;
	assign hwdata_unused = ^{hwdata[31:8], hsize};

	// capture write address phase
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= bpt_pkg::RST_BYTE;
		end else if (hready) begin
			wr_pend_q <= hsel && htrans == bpt_pkg::HTRANS_NONSEQ && hwrite && addr_ok;
			wr_addr_q <= byte_addr;
		end
	end

	// register writes in the data phase
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg_q    <= '0; // RULE_03
			tag_go_q <= 1'b0;
		end else begin
			tag_go_q <= 1'b0;
			if (wr_pend_q) begin
				case (wr_addr_q)
					bpt_pkg::IDX_CTRL0:     cfg_q.ctrl0     <= hwdata[7:0] & bpt_pkg::CTRL0_MASK;
					bpt_pkg::IDX_CTRL1:     cfg_q.ctrl1     <= hwdata[7:0] & bpt_pkg::CTRL1_MASK;
					bpt_pkg::IDX_ADDR_HIGH: cfg_q.addr_high <= hwdata[7:0];
					bpt_pkg::IDX_ADDR_LOW:  cfg_q.addr_low  <= hwdata[7:0];
					bpt_pkg::IDX_DATA_HIGH: cfg_q.data_high <= hwdata[7:0];
					bpt_pkg::IDX_DATA_LOW:  cfg_q.data_low  <= hwdata[7:0];
					bpt_pkg::IDX_TAG_CTRL:  tag_go_q <= hwdata[bpt_pkg::POS_TAG_GO];
					default:                tag_go_q <= 1'b0;
				endcase
			end
		end
	end

	// read mux, unmapped reads as zero
	always_comb begin
		case (byte_addr)
			bpt_pkg::IDX_CTRL0:     rd_data = cfg_q.ctrl0;
			bpt_pkg::IDX_CTRL1:     rd_data = cfg_q.ctrl1;
			bpt_pkg::IDX_ADDR_HIGH: rd_data = cfg_q.addr_high;
			bpt_pkg::IDX_ADDR_LOW:  rd_data = cfg_q.addr_low;
			bpt_pkg::IDX_DATA_HIGH: rd_data = cfg_q.data_high;
			bpt_pkg::IDX_DATA_LOW:  rd_data = cfg_q.data_low;
			bpt_pkg::IDX_STATUS:    rd_data = {4'h0, bp1_hit_q, bp0_hit_q, bdm_active, tagging_q};
			default:                rd_data = bpt_pkg::RST_BYTE;
		endcase
	end

	// read data registered for the data phase
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready) begin
			hrdata <= (hsel && htrans == bpt_pkg::HTRANS_NONSEQ && !hwrite && addr_ok)
				? {24'h00_0000, rd_data} : 32'h0000_0000;
		end
	end

	// ---- comparators ----
	assign mode    = bpt_pkg::bpt_mode_t'(cfg_q.ctrl0[bpt_pkg::POS_MODE_HI:bpt_pkg::POS_MODE_LO]);
	assign dual    = mode == bpt_pkg::MODE_SWI_DUAL || mode == bpt_pkg::MODE_DBG_DUAL; // RULE_14
	assign data_en = cfg_q.ctrl1[bpt_pkg::POS_DATA_EN]; // RULE_15

	// breakpoint 0: address high always, low by range control
	bpt_cmp u_bp0 (
		.enable    (cpu_bus.valid && mode != bpt_pkg::MODE_OFF && !bdm_active), // RULE_14
		.ref_high  (cfg_q.addr_high),                                         // RULE_03
		.ref_low   (cfg_q.addr_low),
		.use_high  (1'b1),
		.use_low   (cfg_q.ctrl0[bpt_pkg::POS_BP0_RANGE]),                     // RULE_04
		.rw_enable (mode != bpt_pkg::MODE_SWI_DUAL && cfg_q.ctrl1[bpt_pkg::POS_BP0_RWE]), // RULE_01
		.rw_value  (cfg_q.ctrl1[bpt_pkg::POS_BP0_RW]),
		.bus_high  (cpu_bus.addr[15:8]),
		.bus_low   (cpu_bus.addr[7:0]),
		.bus_rd    (cpu_bus.rd),
		.hit       (bp0_hit)
	);

	// breakpoint 1: second address from data registers in dual modes
	bpt_cmp u_bp1 (
		.enable    (cpu_bus.valid && dual && data_en && !bdm_active), // RULE_05 RULE_15
		.ref_high  (cfg_q.data_high),
		.ref_low   (cfg_q.data_low),
		.use_high  (1'b1),                                            // RULE_05
		.use_low   (cfg_q.ctrl0[bpt_pkg::POS_BP1_RANGE]),             // RULE_06
		.rw_enable (mode == bpt_pkg::MODE_DBG_DUAL && cfg_q.ctrl1[bpt_pkg::POS_BP1_RWE]), // RULE_02
		.rw_value  (cfg_q.ctrl1[bpt_pkg::POS_BP1_RW]),
		.bus_high  (cpu_bus.addr[15:8]),
		.bus_low   (cpu_bus.addr[7:0]),
		.bus_rd    (cpu_bus.rd),
		.hit       (bp1_hit)
	);

	// full mode data compare with byte masks
	assign full_data_ok = !data_en ||                                                  // RULE_15
		((cfg_q.ctrl1[bpt_pkg::POS_MASK_HIGH] || cpu_bus.data[15:8] == cfg_q.data_high) && // RULE_05 RULE_16
		 (cfg_q.ctrl1[bpt_pkg::POS_MASK_LOW] || cpu_bus.data[7:0] == cfg_q.data_low));     // RULE_06 RULE_16

	// registered break outputs
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bp0_hit_q     <= 1'b0;
			bp1_hit_q     <= 1'b0;
			swi_request_q <= 1'b0;
			bdm_request_q <= 1'b0;
		end else begin
			bp0_hit_q     <= bp0_hit && (dual || full_data_ok); // RULE_17
			bp1_hit_q     <= bp1_hit;                            // RULE_17
			swi_request_q <= mode == bpt_pkg::MODE_SWI_DUAL && (bp0_hit || bp1_hit);
			bdm_request_q <= (mode == bpt_pkg::MODE_FULL && bp0_hit && full_data_ok) ||
				(mode == bpt_pkg::MODE_DBG_DUAL && (bp0_hit || bp1_hit)); // RULE_17
		end
	end

	// ---- tagging ----
	// pin synchronisers: two flops before any logic reads them
	always_ff @(posedge clk) begin
		if (!resetn) begin
			external_bus_clock_sync_q <= 3'h0;
			tlo_sync_q  <= 2'h3;
			thi_sync_q  <= 2'h3;
		end else begin
			external_bus_clock_sync_q <= {external_bus_clock_sync_q[1:0], external_bus_clock};
			tlo_sync_q  <= {tlo_sync_q[0], byte_strobe_pin}; // RULE_07
			thi_sync_q  <= {thi_sync_q[0], background_pin};  // RULE_07
		end
	end
	assign external_bus_clock_fall = external_bus_clock_sync_q[2] && !external_bus_clock_sync_q[1]; // RULE_08

	// tagging mode entry and exit
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tagging_q <= 1'b0;
		end else if (bdm_active) begin
			tagging_q <= 1'b0; // RULE_11
		end else if (tagging_start_command || tag_go_q) begin
			tagging_q <= 1'b1; // RULE_07 RULE_11
		end
	end

	// sample tag levels on each falling external clock edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tag_latch_q <= 2'h0;
		end else if (!tagging_q) begin
			tag_latch_q <= 2'h0;
		end else if (external_bus_clock_fall) begin
			tag_latch_q[1] <= !thi_sync_q[1]; // RULE_08 RULE_09 RULE_10
			tag_latch_q[0] <= !tlo_sync_q[1]; // RULE_08 RULE_09 RULE_10
		end
	end

	// serial commands are held off while tagging
	assign serial_cmd_accept = serial_cmd_valid && !tagging_q; // RULE_12

	// queue carries the tag alongside its word
	assign qin.word = fetch_word;
	assign qin.tag  = tag_latch_q; // RULE_13

	bpt_queue #(
		.DEPTH (QDEPTH)
	) u_queue (
		.clk        (clk),
		.resetn     (resetn),
		.push       (fetch_push),
		.in_word    (qin),
		.pop        (exec_pop),
		.head_q     (qhead),
		.head_valid (head_valid)
	);
	assign head_word = qhead.word;

	// tagged head requests background mode instead of execution
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tag_break_q <= 1'b0;
		end else begin
			tag_break_q <= head_valid && (qhead.tag != 2'h0) && !bdm_active; // RULE_13
		end
	end
endmodule

// ===== bench/bpt_host.sv
/*
 * debug host model: runs the external bus clock and drives the two tag pins.
 * assumes the bench asks for tags as one bit per byte, 1 meaning tag that byte.
 */
`timescale 1ns/10ps
module bpt_host (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// requested tags, bit 1 high byte, bit 0 low byte
	input  wire logic [1:0] tag_req,
	// pins
	output logic            external_bus_clock,
	output logic            byte_strobe_pin,
	output logic            background_pin
);
	logic [2:0] div_q;

	// bus clock at clk/8; pins move only at its rise so they stand still at the fall
	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_q <= 3'h0;
			external_bus_clock <= 1'b0;
			byte_strobe_pin <= 1'b1;
			background_pin <= 1'b1;
		end else begin
			div_q <= div_q + 3'h1;
			if (div_q == 3'h3) begin
				external_bus_clock <= 1'b1;
				byte_strobe_pin <= !tag_req[0];
				background_pin <= !tag_req[1];
			end
			if (div_q == 3'h7)
				external_bus_clock <= 1'b0;
		end
	end
endmodule

// ===== bench/bpt_top_properties.sv
/*
 * port checker for the breakpoint and tagging block.
 * assumes it is bound to bpt_top and mirrors the control and comparator registers.
 */
`timescale 1ns/10ps
module bpt_top_props (
	// clock and reset
	input wire logic              clk,
	input wire logic              resetn,
	// register bus
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic [31:0]       hwdata,
	input wire logic              hready,
	// cpu and debug side
	input wire bpt_pkg::bpt_bus_t cpu_bus,
	input wire logic              bdm_active,
	input wire logic              tagging_start_command,
	input wire logic              serial_cmd_accept,
	input wire logic              head_valid,
	// break outputs
	input wire logic              bp0_hit_q,
	input wire logic              bp1_hit_q,
	input wire logic              tag_break_q
);
	bpt_pkg::bpt_cfg_t cf_q;
	bpt_pkg::bpt_cfg_t pc;
	bpt_pkg::bpt_bus_t bq;
	logic              wr_q;
	logic [2:0]        ix_q;
	logic [1:0]        md;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// register mirror: address phase, then the byte lands at the end of the data phase
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cf_q <= '0;
			wr_q <= 1'b0;
		end else begin
			wr_q <= hsel && hready && htrans == bpt_pkg::HTRANS_NONSEQ && hwrite
				&& haddr[31:5] == 27'h4;
			ix_q <= haddr[4:2];
			if (wr_q)
				case (ix_q)
				3'h0: cf_q.ctrl0 <= hwdata[7:0] & bpt_pkg::CTRL0_MASK;
				3'h1: cf_q.ctrl1 <= hwdata[7:0] & bpt_pkg::CTRL1_MASK;
				3'h2: cf_q.addr_high <= hwdata[7:0];
				3'h3: cf_q.addr_low <= hwdata[7:0];
				3'h4: cf_q.data_high <= hwdata[7:0];
				3'h5: cf_q.data_low <= hwdata[7:0];
				default: ;
				endcase
		end
	end

	// settings and bus as the comparators saw them one cycle before a hit
	always_ff @(posedge clk) begin
		pc <= cf_q;
		bq <= cpu_bus;
	end
	assign md = pc.ctrl0[7:6];

	property p_hi;
		bp0_hit_q |-> bq.valid && md != 2'b00 && bq.addr[15:8] == pc.addr_high;
	endproperty
	a_hi: assert property (p_hi) else $error("bp0 high address");
	property p_lo;
		bp0_hit_q && pc.ctrl0[2] |-> bq.addr[7:0] == pc.addr_low;
	endproperty
	a_lo: assert property (p_lo) else $error("bp0 low address");
	property p_rw0;
		bp0_hit_q && pc.ctrl1[1] && md != 2'b01 |-> bq.rd == pc.ctrl1[0];
	endproperty
	a_rw0: assert property (p_rw0) else $error("bp0 read write");
	property p_dat;
		bp0_hit_q && md == 2'b10 && pc.ctrl1[7] |-> (pc.ctrl1[6] || bq.data[15:8]
			== pc.data_high) && (pc.ctrl1[5] || bq.data[7:0] == pc.data_low);
	endproperty
	a_dat: assert property (p_dat) else $error("bp0 data");
	property p_b1;
		bp1_hit_q |-> bq.valid && md[0] && pc.ctrl1[7] && bq.addr[15:8] == pc.data_high;
	endproperty
	a_b1: assert property (p_b1) else $error("bp1 high address");
	property p_b1lo;
		bp1_hit_q && pc.ctrl0[3] |-> bq.addr[7:0] == pc.data_low;
	endproperty
	a_b1lo: assert property (p_b1lo) else $error("bp1 low address");
	property p_rw1;
		bp1_hit_q && pc.ctrl1[3] && md == 2'b11 |-> bq.rd == pc.ctrl1[2];
	endproperty
	a_rw1: assert property (p_rw1) else $error("bp1 read write");
	property p_bdm;
		bdm_active |=> !bp0_hit_q && !bp1_hit_q;
	endproperty
	a_bdm: assert property (p_bdm) else $error("hit in debug mode");
	property p_ser;
		tagging_start_command && !bdm_active |=> !serial_cmd_accept;
	endproperty
	a_ser: assert property (p_ser) else $error("serial taken while tagging");
	property p_tb;
		tag_break_q |-> $past(head_valid);
	endproperty
	a_tb: assert property (p_tb) else $error("tag break without head");
endmodule

bind bpt_top bpt_top_props u_props (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .cpu_bus, .bdm_active, .tagging_start_command, .serial_cmd_accept, .head_valid,
	.bp0_hit_q, .bp1_hit_q, .tag_break_q);

// ===== bench/breakpoint_compare_and_tagging_tb.sv
/*
 * self-checking bench: register access, random compare traffic, instruction tagging.
 * assumes the host model drives the tag pins and the bench plays cpu and debug core.
 */
`timescale 1ns/10ps
module breakpoint_compare_and_tagging_tb;
	logic              clk = 1'b0;
	logic              resetn = 1'b0;
	logic              hsel = 1'b1;
	logic              hwrite = 1'b0;
	logic [1:0]        htrans = 2'b00;
	logic [31:0]       haddr = 32'h0;
	logic [31:0]       hwdata = 32'h0;
	logic [31:0]       hrdata, rd;
	logic              hreadyout, hresp, head_valid, serial_cmd_accept;
	bpt_pkg::bpt_bus_t cpu_bus = '0;
	logic              fetch_push = 1'b0;
	logic              exec_pop = 1'b0;
	logic [15:0]       fetch_word = 16'h0;
	logic [15:0]       head_word, a, d, w;
	logic              external_bus_clock, byte_strobe_pin, background_pin;
	logic              tagging_start_command = 1'b0;
	logic              bdm_active = 1'b0;
	logic              serial_cmd_valid = 1'b0;
	logic              bp0_hit_q, bp1_hit_q, swi_request_q, bdm_request_q, tag_break_q;
	logic [1:0]        tag_req = 2'b00;
	logic [7:0]        cf [6];
	logic [3:0]        eq [$];
	logic [3:0]        ex;
	logic [1:0]        eh;
	logic [31:0]       r;
	logic              hit;
	integer            seed = 2;
	int                n_mismatch = 0;
	int                n_compared = 0;

	bpt_top dut (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .cpu_bus, .fetch_push, .fetch_word,
		.exec_pop, .head_word, .head_valid, .external_bus_clock, .byte_strobe_pin,
		.background_pin, .tagging_start_command, .bdm_active, .serial_cmd_valid,
		.serial_cmd_accept, .bp0_hit_q, .bp1_hit_q, .swi_request_q, .bdm_request_q,
		.tag_break_q);
	bpt_host u_host (.clk, .resetn, .tag_req, .external_bus_clock, .byte_strobe_pin,
		.background_pin);

	// clock
	always #12.5 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one ahb-lite single transfer, entered just after a rising edge
	task automatic ahb(input logic wr, input logic [7:0] off, input logic [31:0] wd);
		haddr <= {22'h0, off, 2'b00};
		hwrite <= wr;
		htrans <= bpt_pkg::HTRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(hresp, 1'b0);
	endtask

	// reference comparator: returns {bp1, bp0}
	function automatic logic [1:0] exp_hit(input logic [15:0] a, d, input logic rw, v, bd);
		logic [1:0] m;
		logic       h0, h1;
		m = cf[0][7:6];
		h0 = m != 0 && a[15:8] == cf[2] && (!cf[0][2] || a[7:0] == cf[3])
			&& (m == 1 || !cf[1][1] || rw == cf[1][0]) && (m != 2 || !cf[1][7]
			|| ((cf[1][6] || d[15:8] == cf[4]) && (cf[1][5] || d[7:0] == cf[5])));
		h1 = m[0] && cf[1][7] && a[15:8] == cf[4] && (!cf[0][3] || a[7:0] == cf[5])
			&& (m == 1 || !cf[1][3] || rw == cf[1][2]);
		return (v && !bd) ? {h1, h0} : 2'b00;
	endfunction

	// watchdog
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end

	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			ahb(1'b0, bpt_pkg::IDX_CTRL0 + 8'(i), 32'h0);
			chk(rd, 32'h0);
		end
		ahb(1'b1, 8'h30, 32'hff);
		ahb(1'b0, 8'h30, 32'h0);
		chk(rd, 32'h0);
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 6; k++) begin
				cf[0] = {2'(m), 6'($random(seed))} & 8'hcc;
				cf[1] = 8'($random(seed)) & bpt_pkg::CTRL1_MASK;
				for (int j = 2; j < 6; j++)
					cf[j] = 8'($random(seed));
				for (int j = 0; j < 6; j++) begin
					ahb(1'b1, bpt_pkg::IDX_CTRL0 + 8'(j), {24'h0, cf[j]});
					ahb(1'b0, bpt_pkg::IDX_CTRL0 + 8'(j), 32'h0);
					chk(rd, {24'h0, cf[j]});
				end
				// back-to-back bus cycles, each outcome checked one edge later
				eq.push_back(4'h0);
				for (int n = 0; n < 17; n++) begin
					r = $random(seed);
					a = r[1] ? {cf[2], cf[3]} : {cf[4], cf[5]};
					if (r[2])
						a = a ^ (16'h1 << r[7:4]);
					d = r[3] ? {cf[4], cf[5]} : r[31:16];
					cpu_bus <= {n < 16 && (r[8] || r[9]), a, d, r[10]};
					bdm_active <= r[14:11] == 4'h0;
					eh = exp_hit(a, d, r[10], n < 16 && (r[8] || r[9]), r[14:11] == 4'h0);
					eq.push_back({cf[0][7:6] == 2'b01 && eh != 2'b00, cf[0][7] && eh != 2'b00, eh});
					@(posedge clk);
					ex = eq.pop_front();
					chk({bp1_hit_q, bp0_hit_q}, ex[1:0]);
					chk({swi_request_q, bdm_request_q}, ex[3:2]);
				end
				eq.delete();
				bdm_active <= 1'b0;
			end
		end
		// tagging: pins ignored before the command, then any low pin tags its byte
		for (int t = 0; t < 5; t++) begin
			if (t == 4) begin
				ahb(1'b1, bpt_pkg::IDX_TAG_CTRL, 32'h1);
				@(posedge clk);
				ahb(1'b0, bpt_pkg::IDX_STATUS, 32'h0);
				chk(rd, 32'h1);
			end else if (t > 0) begin
				tagging_start_command <= 1'b1;
				@(posedge clk);
				tagging_start_command <= 1'b0;
			end
			tag_req <= (t == 0) ? 2'b11 : 2'(t - 1);
			serial_cmd_valid <= 1'b1;
			repeat (16) @(posedge clk);
			chk(serial_cmd_accept, t == 0);
			w = 16'($random(seed));
			fetch_push <= 1'b1;
			fetch_word <= w;
			@(posedge clk);
			fetch_push <= 1'b0;
			tag_req <= 2'b00;
			hit = 1'b0;
			repeat (24) begin
				@(posedge clk);
				if (tag_break_q === 1'b1)
					hit = 1'b1;
			end
			chk(hit, t > 1);
			chk({head_valid, head_word}, {1'b1, w});
			bdm_active <= 1'b1;
			@(posedge clk);
			@(posedge clk);
			chk(serial_cmd_accept, 1'b1);
			exec_pop <= 1'b1;
			bdm_active <= 1'b0;
			@(posedge clk);
			exec_pop <= 1'b0;
			@(posedge clk);
		end
		wrap_up();
	end
endmodule
